// file: gioc_cell.sv
// General-purpose I/O logic cell for one pad: input, output and output-enable registers,
// double-edge capture and launch, alternate input, clock output and pad buffer settings.
// Assumes the input and output clocks, the pad and the configuration flag arrive asynchronously.
//
// Notes on behaviour
// - Input mode: only pad-to-core path, optionally registered on chosen input-clock edge.
// - Alternate input path carries the pad value with no register option.
// - Double-edge input: rising and falling input-clock samples give two streams.
// - Output mode: only core-to-pad path, optionally registered on chosen output-clock edge.
// - Output and bidirectional modes can invert the output register value.
// - Double-edge output: rising and falling captures multiplexed onto the pad.
// - Bidirectional: input, output and enable paths active, each edge selectable.
// - Input register uses input clock; output and enable registers use output clock.
// - Bidirectional input and output paths registered independently.
// - Clock output mode drives the pad from the core clock tree.
// - Enable register controls the buffer in bidirectional mode only; disabled buffer leaves pad high impedance.
// - During configuration every pin is high impedance with weak pull-up.
// - Unused pins float with pull-up, or pull-down when so configured.
// - Alternate input feeds another block directly, bypassing the core interface.
// - Selectable weak pull-up, weak pull-down and Schmitt-trigger input.
// - Four drive strengths and a slow-edge bit: set slow, clear fast.
// - Double-edge input: rising sample on bit 0, falling sample on bit 1.
`timescale 1ns/1ns

module gioc_cell (
  input wire logic core_clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [gioc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Core side
  input wire gioc_pkg::gioc_core_out_t coreOut,
  output gioc_pkg::gioc_core_in_t coreIn,
  // Clocks from the core clock tree and configuration flag
  input wire logic inClk,
  input wire logic outClk,
  input wire logic cfgBusy,
  // Pad
  input wire logic padIn,
  output logic padOut,
  output logic padOe,
  output gioc_pkg::gioc_buf_t padBuf
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [gioc_pkg::SYN_W-1:0] syncA_r;
  logic [gioc_pkg::SYN_W-1:0] syncB_r;
  logic [gioc_pkg::SYN_W-1:0] syncC_r;

  // First stage is read only by the second; edges come from stages two and three
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_r <= '0;
      syncB_r <= '0;
      syncC_r <= '0;
    end else begin
      syncA_r <= {cfgBusy, outClk, inClk, padIn};
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
    end
  end

  logic padS;
  logic inRise;
  logic inFall;
  logic outRise;
  logic outFall;
  logic outClkLvl;
  logic cfgS;

  assign padS = syncB_r[gioc_pkg::SYN_PAD];
  assign inRise = syncB_r[gioc_pkg::SYN_INCLK] & ~syncC_r[gioc_pkg::SYN_INCLK];
  assign inFall = ~syncB_r[gioc_pkg::SYN_INCLK] & syncC_r[gioc_pkg::SYN_INCLK];
  assign outRise = syncB_r[gioc_pkg::SYN_OUTCLK] & ~syncC_r[gioc_pkg::SYN_OUTCLK];
  assign outFall = ~syncB_r[gioc_pkg::SYN_OUTCLK] & syncC_r[gioc_pkg::SYN_OUTCLK];
  assign outClkLvl = syncB_r[gioc_pkg::SYN_OUTCLK];
  assign cfgS = syncB_r[gioc_pkg::SYN_CFG];

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  gioc_pkg::gioc_ctrl_t ctrl_r;
  gioc_pkg::gioc_ctrl_t ctrl_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wait_r;
  logic wait_nxt;
  logic [31:0] ctrlWord;
  logic [31:0] statusWord;
  logic [1:0] inData_r;

  assign statusWord = {27'h0000000, cfgS, padS, coreOut.oe, inData_r};

  // One wait cycle: answer lands on the second edge of a request, then waitrequest rises again
  always_comb begin
    ctrlWord = ctrl_r;
    ctrl_nxt = ctrl_r;
    rdata_nxt = rdata_r;
    wait_nxt = ~((avs_read | avs_write) & wait_r);
    if (avs_read & wait_r) begin
      unique case (avs_address)
        gioc_pkg::OFS_CTRL: rdata_nxt = ctrlWord;
        gioc_pkg::OFS_STATUS: rdata_nxt = statusWord;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (avs_write & ~wait_r & (avs_address == gioc_pkg::OFS_CTRL)) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_byteenable[i]) begin
          ctrlWord[i*8 +: 8] = avs_writedata[i*8 +: 8];
        end
      end
      ctrl_nxt = ctrlWord;
      ctrl_nxt.reserved = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= gioc_pkg::CTRL_RST;
      rdata_r <= 32'h0000_0000;
      wait_r <= 1'b1;
    end else begin
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

  // ----------------------------------------------------------------
  // Register edge selection
  // ----------------------------------------------------------------
  logic inTick;
  logic outTick;
  logic oeTick;
  logic dblEdgeIn;
  logic dblEdgeOut;
  logic modeIn;
  logic modeOut;
  logic modeBidir;
  logic modeClk;

  assign inTick = (ctrl_r.inEdge == gioc_pkg::EDGE_FALL) ? inFall : inRise;
  assign outTick = (ctrl_r.outEdge == gioc_pkg::EDGE_FALL) ? outFall : outRise;
  assign oeTick = (ctrl_r.oeEdge == gioc_pkg::EDGE_FALL) ? outFall : outRise;
  assign modeIn = ctrl_r.mode == gioc_pkg::MODE_INPUT;
  assign modeOut = ctrl_r.mode == gioc_pkg::MODE_OUTPUT;
  assign modeBidir = ctrl_r.mode == gioc_pkg::MODE_BIDIR;
  assign modeClk = ctrl_r.mode == gioc_pkg::MODE_CLKOUT;
  // Double-edge operation exists only in plain input and output modes
  assign dblEdgeIn = ctrl_r.doubleEdgeIo & modeIn;
  assign dblEdgeOut = ctrl_r.doubleEdgeIo & modeOut;

  // ----------------------------------------------------------------
  // Input path
  // ----------------------------------------------------------------
  logic [1:0] inData_nxt;
  logic alt_r;
  logic alt_nxt;

  always_comb begin
    inData_nxt = inData_r;
    alt_nxt = 1'b0;
    if (modeIn | modeBidir) begin
      if (dblEdgeIn) begin
        if (inRise) begin
          inData_nxt[0] = padS;
        end
        if (inFall) begin
          inData_nxt[1] = padS;
        end
      end else if (ctrl_r.altSel & modeIn) begin
        // Pad goes straight to the other block; the core sees nothing
        alt_nxt = padS;
        inData_nxt = 2'b00;
      end else if (ctrl_r.inRegEn) begin
        if (inTick) begin
          inData_nxt = {1'b0, padS};
        end
      end else begin
        inData_nxt = {1'b0, padS};
      end
    end else begin
      inData_nxt = 2'b00;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      inData_r <= 2'b00;
      alt_r <= 1'b0;
    end else begin
      inData_r <= inData_nxt;
      alt_r <= alt_nxt;
    end
  end

  assign coreIn = '{inData: inData_r, altIn: alt_r};

  // ----------------------------------------------------------------
  // Output and output-enable paths
  // ----------------------------------------------------------------
  logic [1:0] outQ_r;
  logic [1:0] outQ_nxt;
  logic oeQ_r;
  logic oeQ_nxt;
  logic outVal;
  logic oeVal;

  always_comb begin
    outQ_nxt = outQ_r;
    oeQ_nxt = oeQ_r;
    if (dblEdgeOut) begin
      if (outRise) begin
        outQ_nxt[0] = coreOut.outData[0];
      end
      if (outFall) begin
        outQ_nxt[1] = coreOut.outData[1];
      end
    end else if (ctrl_r.outRegEn) begin
      if (outTick) begin
        outQ_nxt = {1'b0, coreOut.outData[0]};
      end
    end else begin
      outQ_nxt = {1'b0, coreOut.outData[0]};
    end
    if (ctrl_r.oeRegEn) begin
      if (oeTick) begin
        oeQ_nxt = coreOut.oe;
      end
    end else begin
      oeQ_nxt = coreOut.oe;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      outQ_r <= 2'b00;
      oeQ_r <= 1'b0;
    end else begin
      outQ_r <= outQ_nxt;
      oeQ_r <= oeQ_nxt;
    end
  end

  // Launch the rising capture while the output clock is high, the falling one while low
  assign outVal = (dblEdgeOut ? (outClkLvl ? outQ_r[0] : outQ_r[1]) : outQ_r[0]) ^ ctrl_r.invertOut;

  // Output mode always drives; bidirectional mode follows the enable register
  assign oeVal = modeOut | (modeBidir & oeQ_r) | modeClk;

  // ----------------------------------------------------------------
  // Clock output divider
  // ----------------------------------------------------------------
  logic [gioc_pkg::CLKDIV_W-1:0] div_r;
  logic [gioc_pkg::CLKDIV_W-1:0] div_nxt;
  logic clkOut_r;
  logic clkOut_nxt;

  // Clock tree is modelled as a divided copy of core_clk, so one domain suffices
  always_comb begin
    div_nxt = div_r;
    clkOut_nxt = clkOut_r;
    if (!modeClk) begin
      div_nxt = '0;
      clkOut_nxt = 1'b0;
    end else if (div_r == gioc_pkg::CLKDIV_W'(gioc_pkg::CLKOUT_HALF - 1)) begin
      div_nxt = '0;
      clkOut_nxt = ~clkOut_r;
    end else begin
      div_nxt = div_r + gioc_pkg::CLKDIV_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= '0;
      clkOut_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      clkOut_r <= clkOut_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pad drive and buffer settings
  // ----------------------------------------------------------------
  logic padOut_r;
  logic padOut_nxt;
  logic padOe_r;
  logic padOe_nxt;
  gioc_pkg::gioc_buf_t buf_r;
  gioc_pkg::gioc_buf_t buf_nxt;

  // Costs one cycle of pad latency so every pad signal leaves from a flip-flop
  always_comb begin
    padOut_nxt = modeClk ? clkOut_r : outVal;
    padOe_nxt = oeVal;
    buf_nxt.pullUpEn = ctrl_r.pullUpSel;
    buf_nxt.pullDownEn = ctrl_r.pullDownSel;
    buf_nxt.schmittEn = ctrl_r.schmittEn;
    buf_nxt.driveSel = ctrl_r.driveSel;
    buf_nxt.slowSlew = ctrl_r.slowEdge;
    if (cfgS) begin
      padOe_nxt = 1'b0;
      padOut_nxt = 1'b0;
      buf_nxt.pullUpEn = 1'b1;
      buf_nxt.pullDownEn = 1'b0;
    end else if (!ctrl_r.pinUsed) begin
      padOe_nxt = 1'b0;
      padOut_nxt = 1'b0;
      buf_nxt.pullUpEn = ~ctrl_r.unusedPullDown;
      buf_nxt.pullDownEn = ctrl_r.unusedPullDown;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      padOut_r <= 1'b0;
      padOe_r <= 1'b0;
      buf_r <= '{pullUpEn: 1'b1, pullDownEn: 1'b0, schmittEn: 1'b0, driveSel: 2'b00, slowSlew: 1'b0};
    end else begin
      padOut_r <= padOut_nxt;
      padOe_r <= padOe_nxt;
      buf_r <= buf_nxt;
    end
  end

  assign padOut = padOut_r;
  assign padOe = padOe_r;
  assign padBuf = buf_r;

endmodule // gioc_cell

// file: gioc_pkg.sv
// Package for the general-purpose I/O logic cell: register map, control layout, modes.
// Assumes a single 10 MHz core clock and a 32-bit Avalon-MM register bus with word-aligned offsets.
package gioc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ = 10_000_000;
  localparam int unsigned CLKOUT_HZ = 2_500_000;
  localparam int unsigned CLKOUT_HALF = CORE_CLK_HZ / (2 * CLKOUT_HZ);
  localparam int unsigned CLKDIV_W = 8;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Modes and settings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_INPUT = 2'b00,
    MODE_OUTPUT = 2'b01,
    MODE_BIDIR = 2'b10,
    MODE_CLKOUT = 2'b11
  } gioc_mode_t;

  localparam logic EDGE_RISE = 1'b0;
  localparam logic EDGE_FALL = 1'b1;

  // Control word, bit 0 at the bottom of the list
  typedef struct packed {
    logic [12:0] reserved;
    logic unusedPullDown;
    logic slowEdge;
    logic [1:0] driveSel;
    logic schmittEn;
    logic pullDownSel;
    logic pullUpSel;
    logic altSel;
    logic doubleEdgeIo;
    logic invertOut;
    logic oeEdge;
    logic outEdge;
    logic inEdge;
    logic oeRegEn;
    logic outRegEn;
    logic inRegEn;
    gioc_mode_t mode;
    logic pinUsed;
  } gioc_ctrl_t;

  // Data travelling between the core and the cell
  typedef struct packed {
    logic [1:0] outData;
    logic oe;
  } gioc_core_out_t;

  typedef struct packed {
    logic [1:0] inData;
    logic altIn;
  } gioc_core_in_t;

  // Pad buffer settings
  typedef struct packed {
    logic pullUpEn;
    logic pullDownEn;
    logic schmittEn;
    logic [1:0] driveSel;
    logic slowSlew;
  } gioc_buf_t;

  // Synchroniser lanes
  localparam int unsigned SYN_W = 4;
  localparam int unsigned SYN_PAD = 0;
  localparam int unsigned SYN_INCLK = 1;
  localparam int unsigned SYN_OUTCLK = 2;
  localparam int unsigned SYN_CFG = 3;

endpackage

// file: gioc_cell_monitor.sv
// Checker for the I/O logic cell: bus handshake, pad drive states and buffer settings.
// Assumes it is bound to gioc_cell and that CTRL changes only through the register bus.
`timescale 1ns/1ns
module gioc_cell_monitor (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [gioc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire gioc_pkg::gioc_core_out_t coreOut,
  input wire gioc_pkg::gioc_core_in_t coreIn,
  input wire logic cfgBusy,
  input wire logic padOut,
  input wire logic padOe,
  input wire gioc_pkg::gioc_buf_t padBuf
);
  // ----------------
  // Shadow of CTRL
  // ----------------
  // Pad checks wait for a quiet spell, since synchronisers delay every change
  logic [31:0] ctl_r, ctl_nxt;
  logic [2:0] quiet_r, quiet_nxt;
  logic wrCtl, settled, used;
  logic [1:0] mode;
  assign wrCtl = avs_write && !avs_waitrequest && avs_address == gioc_pkg::OFS_CTRL;
  assign settled = quiet_r == 3'h7;
  assign used = settled && ctl_r[0];
  assign mode = ctl_r[2:1];
  always_comb begin
    ctl_nxt = ctl_r;
    quiet_nxt = quiet_r;
    for (int i = 0; i < 4; i++) begin
      if (wrCtl && avs_byteenable[i]) begin
        ctl_nxt[8*i+:8] = avs_writedata[8*i+:8];
      end
    end
    if (wrCtl || cfgBusy) begin
      quiet_nxt = 3'h0;
    end else if (!settled) begin
      quiet_nxt = quiet_r + 3'h1;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r <= 32'h0;
      quiet_r <= 3'h0;
    end else begin
      ctl_r <= ctl_nxt;
      quiet_r <= quiet_nxt;
    end
  end
  // ----------------
  // Assertions
  // ----------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence busReq;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence busAck;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  reset_float_a: assert property ($rose(rst_b) |-> !padOe && padBuf == 6'h20 && coreIn == 3'h0)
    else $error("pad not idle after reset");
  bus_ack_a: assert property (busReq |=> busAck)
    else $error("bus answer not one wait cycle");
  cfg_float_a: assert property (cfgBusy [*5] |-> !padOe && padBuf.pullUpEn && !padBuf.pullDownEn)
    else $error("pad driven during configuration");
  unused_pull_a: assert property (settled && !ctl_r[0] |-> !padOe && padBuf.pullDownEn == ctl_r[18]
    && padBuf.pullUpEn == !ctl_r[18])
    else $error("unused pin pulls wrong");
  buf_sel_a: assert property (used |-> padBuf == {ctl_r[12], ctl_r[13], ctl_r[14], ctl_r[16:15], ctl_r[17]})
    else $error("buffer settings differ from CTRL");
  in_nodrive_a: assert property (used && mode == gioc_pkg::MODE_INPUT |-> !padOe)
    else $error("input mode drives pad");
  out_drive_a: assert property (used && mode == gioc_pkg::MODE_OUTPUT && !ctl_r[4] && !ctl_r[10]
    |-> padOe && padOut == (ctl_r[9] ^ $past(coreOut.outData[0], 2)))
    else $error("output path value wrong");
  bidir_oe_a: assert property (used && mode == gioc_pkg::MODE_BIDIR && !ctl_r[5]
    |-> padOe == $past(coreOut.oe, 2))
    else $error("bidirectional enable wrong");
  clk_out_a: assert property (used && mode == gioc_pkg::MODE_CLKOUT |-> padOe && padOut != $past(padOut, 2))
    else $error("clock output not toggling");
endmodule // gioc_cell_monitor

bind gioc_cell gioc_cell_monitor MON (.core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_waitrequest, .coreOut, .coreIn, .cfgBusy, .padOut, .padOe, .padBuf);

// file: gioc_pad_model.sv
// Board side of the pad: an external driver, the weak pulls, or a floating line.
// Assumes the bench releases boardEn whenever the cell drives the pad.
`timescale 1ns/1ns
module gioc_pad_model (
  input wire logic core_clk,
  input wire logic padOut,
  input wire logic padOe,
  input wire gioc_pkg::gioc_buf_t padBuf,
  input wire logic boardEn,
  input wire logic boardVal,
  output logic padIn
);
  // A floating line flips each cycle so a stale value never passes
  logic last_r = 1'h0;
  always_ff @(posedge core_clk) last_r <= padIn;
  always_comb begin
    if (padOe) padIn = padOut;
    else if (boardEn) padIn = boardVal;
    else if (padBuf.pullUpEn) padIn = 1'h1;
    else if (padBuf.pullDownEn) padIn = 1'h0;
    else padIn = !last_r;
  end
endmodule // gioc_pad_model

// file: gioc_cell_test.sv
// Bench for the I/O logic cell: register bus tasks and pad scenarios per mode.
// Assumes gioc_pad_model on the pad and the bound checker beside the cell.
`timescale 1ns/1ns
module gioc_cell_test;
  logic core_clk, rst_b, avs_read, avs_write, avs_waitrequest, inClk, outClk, cfgBusy;
  logic padIn, padOut, padOe, boardEn, boardVal, p;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  gioc_pkg::gioc_core_out_t coreOut;
  gioc_pkg::gioc_core_in_t coreIn;
  gioc_pkg::gioc_buf_t padBuf;
  int errorCnt, testsRun, n;
  gioc_cell DUT (.core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .coreOut, .coreIn, .inClk, .outClk, .cfgBusy, .padIn, .padOut, .padOe, .padBuf);
  gioc_pad_model PAD (.core_clk, .padOut, .padOe, .padBuf, .boardEn, .boardVal, .padIn);
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  // ----------------
  // Tasks
  // ----------------
  task automatic stopTest;
    $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // Holds the request until waitrequest is sampled low, releases it there, then idles one edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'h0 && k < 50);
    if (avs_waitrequest !== 1'h0) begin
      errorCnt++;
      stopTest();
    end
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [31:0] d);
    bus(1'h1, 4'h0, d, 4'hF);
  endtask
  // ----------------
  // Scenarios
  // ----------------
  initial begin
    rst_b = 1'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    coreOut = 3'h0;
    inClk = 1'h0;
    outClk = 1'h0;
    cfgBusy = 1'h0;
    boardEn = 1'h0;
    boardVal = 1'h0;
    errorCnt = 0;
    testsRun = 0;
    cyc(6);
    rst_b <= 1'h1;
    cyc(2);
    chk(1'h0, padOe);
    chk(6'h20, padBuf);
    chk(3'h0, coreIn);
    bus(1'h0, 4'h0, 32'h0, 4'hF);
    chk(32'h0, rd);
    wr(32'hFFFF_FFFE);
    bus(1'h1, 4'h0, 32'h0, 4'h1);
    bus(1'h0, 4'h0, 32'h0, 4'hF);
    chk(32'h0007_FF00, rd);
    bus(1'h0, 4'h8, 32'h0, 4'hF);
    chk(32'h0, rd);
    cyc(5);
    chk(2'h1, {padBuf.pullUpEn, padBuf.pullDownEn});
    $display("test reset and registers done");
    wr(32'h0003_5801);
    boardEn <= 1'h1;
    for (int i = 0; i < 2; i++) begin
      boardVal <= ~i[0];
      cyc(6);
      chk(1'h0, padOe);
      chk(1'h0, coreIn.inData[0]);
      chk(!i[0], coreIn.altIn);
    end
    chk(6'h2D, padBuf);
    wr(32'h49);
    boardVal <= 1'h1;
    cyc(5);
    inClk <= 1'h1;
    cyc(5);
    chk(1'h0, coreIn.inData[0]);
    inClk <= 1'h0;
    cyc(5);
    chk(1'h1, coreIn.inData[0]);
    wr(32'h409);
    boardVal <= 1'h0;
    cyc(4);
    inClk <= 1'h1;
    cyc(5);
    boardVal <= 1'h1;
    cyc(4);
    inClk <= 1'h0;
    cyc(5);
    chk(2'h2, coreIn.inData);
    $display("test input modes done");
    boardEn <= 1'h0;
    // Last pass leaves the output register clear, so the registered capture below shows
    // Long dwell lets the checker's quiet spell end inside each pass
    for (int i = 3; i >= 0; i--) begin
      wr({22'h0, i[1], 9'h3});
      coreOut.outData <= {1'h0, i[0]};
      cyc(9);
      chk(1'h1, padOe);
      chk(i[0] ^ i[1], padOut);
    end
    wr(32'h13);
    coreOut.outData <= 2'h1;
    outClk <= 1'h1;
    cyc(5);
    chk(1'h1, padOut);
    coreOut.outData <= 2'h0;
    cyc(5);
    chk(1'h1, padOut);
    outClk <= 1'h0;
    cyc(5);
    chk(1'h1, padOut);
    wr(32'h413);
    coreOut.outData <= 2'h2;
    outClk <= 1'h1;
    cyc(5);
    chk(1'h0, padOut);
    outClk <= 1'h0;
    cyc(5);
    chk(1'h1, padOut);
    $display("test output modes done");
    wr(32'h5);
    coreOut <= 3'h2;
    boardEn <= 1'h1;
    cyc(6);
    chk(1'h0, padOe);
    chk(1'h1, coreIn.inData[0]);
    boardEn <= 1'h0;
    coreOut.oe <= 1'h1;
    cyc(5);
    chk(2'h3, {padOe, padOut});
    $display("test bidirectional done");
    wr(32'h7);
    cyc(8);
    n = 0;
    repeat (16) begin
      p = padOut;
      @(posedge core_clk);
      if (padOut !== p) n++;
    end
    chk(8, n);
    cfgBusy <= 1'h1;
    cyc(6);
    chk(3'h4, {padBuf.pullUpEn, padBuf.pullDownEn, padOe});
    cfgBusy <= 1'h0;
    cyc(6);
    chk(1'h1, padOe);
    $display("test clock output and configuration done");
    stopTest();
  end
endmodule // gioc_cell_test
